// >>> rtl/acl_rule_match_resolver.sv
`timescale 1ns/1ps
`default_nettype none
`include "acl_consts.svh"

// Summary of operation
// - One action per packet; lowest action pointer among true entries wins.
// - Several processing entries naming one action are ORed together.
// - A processing entry is true only if all its selected matches are true.
// - A counting match entry uses the same-index action entry as count value.
// - Mode and option select entry meaning; mode 00 disables the entry.
// - Layer-2 options: 01 MAC only, 10 EtherType only, 11 both.
// - Layer-2 option 00 is count mode testing MAC and EtherType.
// - Layer-3: 01 one address under mask, 10 both addresses; others reserved.
// - Layer-4: protocol, TCP port, UDP port or TCP sequence number.
// - Side bit picks destination when 0, source when 1.
// - Equality sense: 0 true on mismatch, 1 true on match.
// - Processing entry: 16-bit match-set mask and 4-bit action pointer.
// - Down-count mode reloads on packet, counts time units, flags expiry.
// - Unit bit picks us or ms; up mode counts packets to terminal.
module acl_rule_match_resolver #(
    parameter int US_CYCLES = `ACL_US_NS / `ACL_CLK_NS,
    parameter int US_PER_MS = `ACL_US_PER_MS
) (
    // Clock and reset
    input  wire logic                       CLK,
    input  wire logic                       RSTN,
    // Table programming
    input  wire logic                       CFG_WE,
    input  wire logic [1:0]                 CFG_SEL,
    input  wire logic [`ACL_PTR_W-1:0]      CFG_INDEX,
    input  wire acl_pkg::match_entry_type   CFG_MATCH,
    input  wire acl_pkg::action_entry_type  CFG_ACTION,
    input  wire acl_pkg::proc_entry_type    CFG_PROC,
    // Packet header from parser
    input  wire logic                       PKT_VALID,
    input  wire logic [`ACL_MAC_W-1:0]      PKT_DST_MAC,
    input  wire logic [`ACL_MAC_W-1:0]      PKT_SRC_MAC,
    input  wire logic [`ACL_TYPE_W-1:0]     PKT_ETHER_TYPE,
    input  wire logic [`ACL_IP_W-1:0]       PKT_DST_IP,
    input  wire logic [`ACL_IP_W-1:0]       PKT_SRC_IP,
    input  wire logic [`ACL_PROTO_W-1:0]    PKT_IP_PROTO,
    input  wire logic                       PKT_IS_TCP,
    input  wire logic                       PKT_IS_UDP,
    input  wire logic [`ACL_PORT_W-1:0]     PKT_DST_PORT,
    input  wire logic [`ACL_PORT_W-1:0]     PKT_SRC_PORT,
    input  wire logic [`ACL_IP_W-1:0]       PKT_TCP_SEQ,
    // Decision to forwarding logic
    output logic                            RESULT_VALID,
    output logic                            ACTION_HIT,
    output logic [`ACL_PTR_W-1:0]           ACTION_INDEX,
    output logic [`ACL_ACTION_W-1:0]        ACTION_DATA,
    output logic [`ACL_ENTRIES-1:0]         MATCH_RESULTS,
    // Count events
    output logic [`ACL_ENTRIES-1:0]         COUNT_EVENT
);

    localparam int N = `ACL_ENTRIES;

    typedef struct packed {
        acl_pkg::match_entry_type  [N-1:0]  match_tab;
        acl_pkg::action_entry_type [N-1:0]  action_tab;
        acl_pkg::proc_entry_type   [N-1:0]  proc_tab;
        logic [15:0]                        us_cnt;
        logic [15:0]                        ms_cnt;
        logic                               us_tick;
        logic                               ms_tick;
        logic                               res_valid;
        logic                               res_hit;
        logic [`ACL_PTR_W-1:0]              res_index;
        logic [`ACL_ACTION_W-1:0]           res_data;
        logic [N-1:0]                       res_match;
        logic [N-1:0]                       touch;
    } state_type;

    state_type s_q;
    state_type s_d;

    logic [N-1:0]               match_hit;
    logic [N-1:0]               count_mode;
    logic [N-1:0]               proc_true;
    logic [N-1:0]               action_req;
    logic [N-1:0]               reload;

    // True when every selected match is true and at least one is selected
    function automatic logic set_true(input logic [N-1:0] mask,
                                      input logic [N-1:0] hits);
        set_true = (mask != '0) && ((mask & ~hits) == '0);
    endfunction : set_true

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_entry
            acl_match_compare u_cmp (
                .entry      (s_q.match_tab[g]),
                .dst_mac    (PKT_DST_MAC),
                .src_mac    (PKT_SRC_MAC),
                .ether_type (PKT_ETHER_TYPE),
                .dst_ip     (PKT_DST_IP),
                .src_ip     (PKT_SRC_IP),
                .ip_proto   (PKT_IP_PROTO),
                .is_tcp     (PKT_IS_TCP),
                .is_udp     (PKT_IS_UDP),
                .dst_port   (PKT_DST_PORT),
                .src_port   (PKT_SRC_PORT),
                .tcp_seq    (PKT_TCP_SEQ),
                .hit        (match_hit[g]),
                .count_mode (count_mode[g])
            );

            // Restart a counting pair one cycle after a write to either
            // half, so it loads the new entry rather than the old one
            assign reload[g] = s_q.touch[g];

            acl_count_timer u_cnt (
                .clk                    (CLK),
                .rst_n                  (RSTN),
                .enable                 (count_mode[g]),
                .reload                 (reload[g]),
                .count_algorithm_select
                    (s_q.action_tab[g].count_algorithm_select),
                .count_time_unit        (s_q.action_tab[g].count_time_unit),
                .count_value
                    (s_q.action_tab[g].payload[`ACL_COUNT_W-1:0]),
                .hit                    (PKT_VALID && match_hit[g]),
                .us_tick                (s_q.us_tick),
                .ms_tick                (s_q.ms_tick),
                .count                  (),
                .expired                (COUNT_EVENT[g])
            );
        end
    endgenerate

    always_comb begin
        s_d = s_q;
        proc_true  = '0;
        action_req = '0;

        // Time base: microsecond tick, millisecond from 1000 of them
        s_d.us_tick = 1'b0;
        s_d.ms_tick = 1'b0;
        if (s_q.us_cnt >= 16'(US_CYCLES - 1)) begin
            s_d.us_cnt  = '0;
            s_d.us_tick = 1'b1;
            if (s_q.ms_cnt >= 16'(US_PER_MS - 1)) begin
                s_d.ms_cnt  = '0;
                s_d.ms_tick = 1'b1;
            end else begin
                s_d.ms_cnt = s_q.ms_cnt + 16'h0001;
            end
        end else begin
            s_d.us_cnt = s_q.us_cnt + 16'h0001;
        end

        // Each processing entry votes for the action it points to
        for (int p = 0; p < N; p++) begin
            proc_true[p] = set_true(s_q.proc_tab[p].match_set_mask,
                                    match_hit);
            if (proc_true[p]) begin
                action_req[s_q.proc_tab[p].action_pointer] = 1'b1;
            end
        end
        // A slot holding a count value carries no forwarding action
        action_req = action_req & ~count_mode;

        // Lowest index wins; scanning downward leaves the smallest
        s_d.res_valid = PKT_VALID;
        s_d.res_match = PKT_VALID ? match_hit : '0;
        s_d.res_hit   = 1'b0;
        s_d.res_index = '0;
        s_d.res_data  = '0;
        if (PKT_VALID) begin
            for (int a = N - 1; a >= 0; a--) begin
                if (action_req[a]) begin
                    s_d.res_hit   = 1'b1;
                    s_d.res_index = a[`ACL_PTR_W-1:0];
                    s_d.res_data  = s_q.action_tab[a];
                end
            end
        end

        s_d.touch = '0;
        if (CFG_WE && (CFG_SEL == `ACL_SEL_MATCH ||
                       CFG_SEL == `ACL_SEL_ACTION)) begin
            s_d.touch[CFG_INDEX] = 1'b1;
        end

        // Table writes; a packet in the same cycle sees the old entry
        if (CFG_WE) begin
            case (CFG_SEL)
                `ACL_SEL_MATCH:  s_d.match_tab[CFG_INDEX]  = CFG_MATCH;
                `ACL_SEL_ACTION: s_d.action_tab[CFG_INDEX] = CFG_ACTION;
                `ACL_SEL_PROC:   s_d.proc_tab[CFG_INDEX]   = CFG_PROC;
                default:         s_d.proc_tab = s_q.proc_tab;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign RESULT_VALID  = s_q.res_valid;
    assign ACTION_HIT    = s_q.res_hit;
    assign ACTION_INDEX  = s_q.res_index;
    assign ACTION_DATA   = s_q.res_data;
    assign MATCH_RESULTS = s_q.res_match;

endmodule : acl_rule_match_resolver

`default_nettype wire

// >>> rtl/acl_consts.svh
`ifndef ACL_CONSTS_SVH
`define ACL_CONSTS_SVH

// Table geometry
`define ACL_ENTRIES      16
`define ACL_PTR_W        4
`define ACL_COUNT_W      11
`define ACL_MAC_W        48
`define ACL_IP_W         32
`define ACL_PORT_W       16
`define ACL_TYPE_W       16
`define ACL_PROTO_W      8
`define ACL_ACTION_W     16

// Mode field codes
`define ACL_MODE_OFF     2'h0
`define ACL_MODE_L2      2'h1
`define ACL_MODE_L3      2'h2
`define ACL_MODE_L4      2'h3

// Option field codes
`define ACL_OPT_0        2'h0
`define ACL_OPT_1        2'h1
`define ACL_OPT_2        2'h2
`define ACL_OPT_3        2'h3

// Side select and equality sense
`define ACL_SIDE_DST     1'b0
`define ACL_SIDE_SRC     1'b1
`define ACL_EQ_MATCH     1'b1

// Count unit and algorithm
`define ACL_TU_US        1'b0
`define ACL_TU_MS        1'b1
`define ACL_CA_DOWN      1'b0
`define ACL_CA_UP        1'b1

// Configuration table select
`define ACL_SEL_MATCH    2'h0
`define ACL_SEL_ACTION   2'h1
`define ACL_SEL_PROC     2'h2

// Timing
`define ACL_CLK_NS       10
`define ACL_US_NS        1000
`define ACL_US_PER_MS    1000

`endif

// >>> rtl/acl_pkg.sv
`include "acl_consts.svh"

package acl_pkg;

    typedef struct packed {
        logic [1:0]                 mode;
        logic [1:0]                 option;
        logic                       side;
        logic                       equality_sense;
        logic [`ACL_MAC_W-1:0]      operand_a;
        logic [`ACL_IP_W-1:0]       operand_b;
    } match_entry_type;

    typedef struct packed {
        logic                       count_time_unit;
        logic                       count_algorithm_select;
        logic [`ACL_ACTION_W-3:0]   payload;
    } action_entry_type;

    typedef struct packed {
        logic [`ACL_ENTRIES-1:0]    match_set_mask;
        logic [`ACL_PTR_W-1:0]      action_pointer;
    } proc_entry_type;

    typedef struct packed {
        logic [`ACL_COUNT_W-1:0]    count;
        logic                       event_out;
    } counter_state_type;

endpackage : acl_pkg

// >>> rtl/acl_match_compare.sv
`timescale 1ns/1ps
`default_nettype none
`include "acl_consts.svh"

module acl_match_compare (
    // Entry
    input  wire acl_pkg::match_entry_type   entry,
    // Packet header
    input  wire logic [`ACL_MAC_W-1:0]      dst_mac,
    input  wire logic [`ACL_MAC_W-1:0]      src_mac,
    input  wire logic [`ACL_TYPE_W-1:0]     ether_type,
    input  wire logic [`ACL_IP_W-1:0]       dst_ip,
    input  wire logic [`ACL_IP_W-1:0]       src_ip,
    input  wire logic [`ACL_PROTO_W-1:0]    ip_proto,
    input  wire logic                       is_tcp,
    input  wire logic                       is_udp,
    input  wire logic [`ACL_PORT_W-1:0]     dst_port,
    input  wire logic [`ACL_PORT_W-1:0]     src_port,
    input  wire logic [`ACL_IP_W-1:0]       tcp_seq,
    // Result
    output logic                            hit,
    output logic                            count_mode
);

    logic [`ACL_MAC_W-1:0]  mac_sel;
    logic [`ACL_IP_W-1:0]   ip_sel;
    logic [`ACL_PORT_W-1:0] port_sel;
    logic [`ACL_PORT_W-1:0] port_min;
    logic [`ACL_PORT_W-1:0] port_max;
    logic                   mac_eq;
    logic                   type_eq;
    logic                   port_in;
    logic                   cmp;
    logic                   valid;

    always_comb begin
        // Side select
        mac_sel  = (entry.side == `ACL_SIDE_SRC) ? src_mac : dst_mac;
        ip_sel   = (entry.side == `ACL_SIDE_SRC) ? src_ip : dst_ip;
        port_sel = (entry.side == `ACL_SIDE_SRC) ? src_port : dst_port;
        port_min = entry.operand_a[`ACL_PORT_W-1:0];
        port_max = entry.operand_a[2*`ACL_PORT_W-1:`ACL_PORT_W];
        mac_eq   = (mac_sel == entry.operand_a);
        type_eq  = (ether_type == entry.operand_b[`ACL_TYPE_W-1:0]);
        port_in  = (port_sel >= port_min) && (port_sel <= port_max);
        cmp      = 1'b0;
        valid    = 1'b1;
        count_mode = 1'b0;
        case (entry.mode)
            `ACL_MODE_L2: begin
                case (entry.option)
                    `ACL_OPT_1: cmp = mac_eq;
                    `ACL_OPT_2: cmp = type_eq;
                    default: begin
                        // Count mode still tests both fields
                        cmp = mac_eq && type_eq;
                        count_mode = (entry.option == `ACL_OPT_0);
                    end
                endcase
            end
            `ACL_MODE_L3: begin
                case (entry.option)
                    `ACL_OPT_1: cmp = ((ip_sel ^ entry.operand_a[`ACL_IP_W-1:0])
                                      & ~entry.operand_b) == '0;
                    `ACL_OPT_2: cmp = (src_ip == entry.operand_a[`ACL_IP_W-1:0])
                                      && (dst_ip == entry.operand_b);
                    default:    valid = 1'b0;
                endcase
            end
            `ACL_MODE_L4: begin
                case (entry.option)
                    `ACL_OPT_0: cmp = (ip_proto ==
                                       entry.operand_a[`ACL_PROTO_W-1:0]);
                    `ACL_OPT_1: cmp = is_tcp && port_in;
                    `ACL_OPT_2: cmp = is_udp && port_in;
                    default:    cmp = is_tcp &&
                                      (tcp_seq == entry.operand_a[`ACL_IP_W-1:0]);
                endcase
            end
            default: valid = 1'b0;
        endcase
        // Reserved and disabled entries never report true
        hit = valid && ((entry.equality_sense == `ACL_EQ_MATCH) ? cmp : !cmp);
    end

endmodule : acl_match_compare

`default_nettype wire

// >>> rtl/acl_count_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "acl_consts.svh"

module acl_count_timer (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    // Configuration
    input  wire logic                       enable,
    input  wire logic                       reload,
    input  wire logic                       count_algorithm_select,
    input  wire logic                       count_time_unit,
    input  wire logic [`ACL_COUNT_W-1:0]    count_value,
    // Events
    input  wire logic                       hit,
    input  wire logic                       us_tick,
    input  wire logic                       ms_tick,
    // Status
    output logic [`ACL_COUNT_W-1:0]         count,
    output logic                            expired
);

    acl_pkg::counter_state_type s_q;
    acl_pkg::counter_state_type s_d;
    logic                       tick;

    always_comb begin
        s_d = s_q;
        s_d.event_out = 1'b0;
        tick = (count_time_unit == `ACL_TU_MS) ? ms_tick : us_tick;
        if (!enable || reload) begin
            // Down mode starts loaded, up mode starts at zero
            s_d.count = (count_algorithm_select == `ACL_CA_DOWN) ?
                        count_value : '0;
        end else if (count_algorithm_select == `ACL_CA_DOWN) begin
            if (hit) begin
                s_d.count = count_value;
            end else if (tick) begin
                if (s_q.count == '0) begin
                    s_d.event_out = 1'b1;
                    s_d.count = count_value;
                end else begin
                    s_d.count = s_q.count - 1'b1;
                end
            end
        end else if (hit) begin
            if (s_q.count + 1'b1 >= count_value) begin
                s_d.event_out = 1'b1;
                s_d.count = '0;
            end else begin
                s_d.count = s_q.count + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign count   = s_q.count;
    assign expired = s_q.event_out;

endmodule : acl_count_timer

`default_nettype wire

// >>> tb/acl_hdr_fields.svh
`ifndef ACL_HDR_FIELDS_SVH
`define ACL_HDR_FIELDS_SVH

// Header field values of test packet kind k (k is 4 bits wide)
`define H_DMAC(k)  {44'h0a000000000, k}
`define H_SMAC(k)  {44'h0b000000000, k}
`define H_TYPE(k)  {12'h080, k}
`define H_DIP(k)   {28'hc0a8000, k}
`define H_SIP(k)   {28'h0a00000, k}
`define H_PROTO(k) {4'h1, k}
`define H_DPORT(k) {12'h005, k}
`define H_SPORT(k) {12'h700, k}
`define H_SEQ(k)   {28'h0001000, k}

`endif

// >>> tb/acl_resolver_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "acl_consts.svh"

module acl_resolver_chk (
    // Clock and reset
    input wire logic                        CLK,
    input wire logic                        RSTN,
    // Requests
    input wire logic                        CFG_WE,
    input wire logic                        PKT_VALID,
    // Decision
    input wire logic                        RESULT_VALID,
    input wire logic                        ACTION_HIT,
    input wire logic [`ACL_PTR_W-1:0]       ACTION_INDEX,
    input wire logic [`ACL_ACTION_W-1:0]    ACTION_DATA,
    input wire logic [`ACL_ENTRIES-1:0]     MATCH_RESULTS,
    input wire logic [`ACL_ENTRIES-1:0]     COUNT_EVENT
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    sequence s_pkt_taken;
        PKT_VALID ##1 RESULT_VALID;
    endsequence

    a_answer_next: assert property (PKT_VALID |=> RESULT_VALID)
        else $error("result strobe missing after packet");
    a_quiet_idle: assert property (!PKT_VALID |=>
        !RESULT_VALID && !ACTION_HIT && MATCH_RESULTS == '0)
        else $error("decision outputs active without packet");
    a_hit_in_result: assert property (ACTION_HIT |-> RESULT_VALID)
        else $error("action hit outside result cycle");
    a_miss_zeroed: assert property (RESULT_VALID && !ACTION_HIT |->
        ACTION_INDEX == '0 && ACTION_DATA == '0)
        else $error("action fields not zero on miss");
    a_hit_has_match: assert property (s_pkt_taken ##0 ACTION_HIT |->
        MATCH_RESULTS != '0)
        else $error("action hit with no true match entry");
    a_reset_quiet: assert property ($rose(RSTN) |->
        !RESULT_VALID && COUNT_EVENT == '0)
        else $error("outputs active right after reset");
    a_write_silent: assert property (CFG_WE && !PKT_VALID |=>
        !RESULT_VALID)
        else $error("table write produced a result");
    a_cleared_after: assert property ($fell(RESULT_VALID) |->
        !ACTION_HIT && ACTION_DATA == '0)
        else $error("action held past result cycle");
endmodule : acl_resolver_chk
`default_nettype wire

// >>> tb/acl_parser_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "acl_hdr_fields.svh"

module acl_parser_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Request from bench
    input  wire logic        send,
    input  wire logic [3:0]  kind,
    // Header to evaluator
    output logic             pkt_valid,
    output logic [47:0]      dst_mac,
    output logic [47:0]      src_mac,
    output logic [15:0]      ether_type,
    output logic [31:0]      dst_ip,
    output logic [31:0]      src_ip,
    output logic [7:0]       ip_proto,
    output logic             is_tcp,
    output logic             is_udp,
    output logic [15:0]      dst_port,
    output logic [15:0]      src_port,
    output logic [31:0]      tcp_seq
);
    logic [249:0] hdr;
    logic [249:0] last_q;

    assign hdr = {`H_DMAC(kind), `H_SMAC(kind), `H_TYPE(kind),
        `H_DIP(kind), `H_SIP(kind), `H_PROTO(kind), kind[0], ~kind[0],
        `H_DPORT(kind), `H_SPORT(kind), `H_SEQ(kind)};

    // Off-strobe fields toggle each cycle so stale sampling shows up
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) last_q <= '0;
        else        last_q <= ~(send ? hdr : last_q);
    end

    assign pkt_valid = send;
    assign {dst_mac, src_mac, ether_type, dst_ip, src_ip, ip_proto, is_tcp,
        is_udp, dst_port, src_port, tcp_seq} = send ? hdr : last_q;
endmodule : acl_parser_model
`default_nettype wire

// >>> tb/acl_rule_match_resolver_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "acl_hdr_fields.svh"

module acl_rule_match_resolver_test;
    logic clk = 1'b0, rst_n = 1'b0, cfg_we = 1'b0, send = 1'b0;
    logic [1:0]  cfg_sel = 2'h0;
    logic [3:0]  cfg_index = 4'h0, kind = 4'h0, action_index;
    logic [85:0] cfg_bits = '0;
    logic        pkt_valid, is_tcp, is_udp, result_valid, action_hit;
    logic [47:0] dst_mac, src_mac;
    logic [15:0] ether_type, dst_port, src_port, action_data;
    logic [15:0] match_results, count_event;
    logic [31:0] dst_ip, src_ip, tcp_seq;
    logic [7:0]  ip_proto;
    int          n_fail = 0;
    int          samples_checked = 0;

    always #5 clk = ~clk;

    acl_parser_model parser (.clk(clk), .rst_n(rst_n), .send(send),
        .kind(kind), .pkt_valid(pkt_valid), .dst_mac(dst_mac),
        .src_mac(src_mac), .ether_type(ether_type), .dst_ip(dst_ip),
        .src_ip(src_ip), .ip_proto(ip_proto), .is_tcp(is_tcp),
        .is_udp(is_udp), .dst_port(dst_port), .src_port(src_port),
        .tcp_seq(tcp_seq));

    // Short time base: one us is 2 cycles, one ms is 2 us
    acl_rule_match_resolver #(.US_CYCLES(2), .US_PER_MS(2)) dut (
        .CLK(clk), .RSTN(rst_n), .CFG_WE(cfg_we), .CFG_SEL(cfg_sel),
        .CFG_INDEX(cfg_index), .CFG_MATCH(cfg_bits),
        .CFG_ACTION(cfg_bits[15:0]), .CFG_PROC(cfg_bits[19:0]),
        .PKT_VALID(pkt_valid), .PKT_DST_MAC(dst_mac),
        .PKT_SRC_MAC(src_mac), .PKT_ETHER_TYPE(ether_type),
        .PKT_DST_IP(dst_ip), .PKT_SRC_IP(src_ip), .PKT_IP_PROTO(ip_proto),
        .PKT_IS_TCP(is_tcp), .PKT_IS_UDP(is_udp), .PKT_DST_PORT(dst_port),
        .PKT_SRC_PORT(src_port), .PKT_TCP_SEQ(tcp_seq),
        .RESULT_VALID(result_valid), .ACTION_HIT(action_hit),
        .ACTION_INDEX(action_index), .ACTION_DATA(action_data),
        .MATCH_RESULTS(match_results), .COUNT_EVENT(count_event));

    task close_out;
        if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out

    task chk(input string what, input logic [31:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    function automatic acl_pkg::match_entry_type mk(input logic [1:0] md,
        opt, input logic sd, eq, input logic [47:0] a, input logic [31:0] b);
        return '{md, opt, sd, eq, a, b};
    endfunction : mk

    task rst;
        rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
    endtask : rst

    // Table write; the select decides which view of cfg_bits is used
    task wr(input logic [1:0] sel, input logic [3:0] idx,
        input logic [85:0] v);
        @(posedge clk);
        cfg_we <= 1'b1;
        cfg_sel <= sel;
        cfg_index <= idx;
        cfg_bits <= v;
        @(posedge clk);
        cfg_we <= 1'b0;
    endtask : wr

    task res(input logic [3:0] k, input logic hit, input logic [3:0] idx,
        input logic [15:0] data);
        @(posedge clk);
        send <= 1'b1;
        kind <= k;
        @(posedge clk);
        send <= 1'b0;
        #1;
        chk("result_valid", 1, result_valid);
        chk("action_hit", hit, action_hit);
        chk("action_index", idx, action_index);
        chk("action_data", data, action_data);
    endtask : res

    task ev(input acl_pkg::match_entry_type m, input logic [3:0] k,
        input logic e);
        wr(2'h0, 4'h0, m);
        res(k, 1'b0, 4'h0, 16'h0000);
        chk("match_result", e, match_results[0]);
    endtask : ev

    task wt(input int lo, hi);
        int n;
        n = 0;
        while (count_event[4] !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("event_delay_in_window", 1, n >= lo && n <= hi);
    endtask : wt

    task t_prio;
        wr(2'h0, 4'h0, mk(2'h1, 2'h1, 1'b0, 1'b1, `H_DMAC(4'h1), 0));
        wr(2'h0, 4'h1, mk(2'h1, 2'h2, 1'b0, 1'b0, 0, `H_TYPE(4'h3)));
        wr(2'h0, 4'h2, mk(2'h1, 2'h1, 1'b0, 1'b0, `H_DMAC(4'h1), 0));
        wr(2'h2, 4'h0, {16'h0006, 4'h9});
        wr(2'h2, 4'h1, {16'h0003, 4'hc});
        wr(2'h2, 4'h2, {16'h0001, 4'h9});
        wr(2'h2, 4'h3, {16'h0005, 4'h1});
        wr(2'h1, 4'h9, 16'h0123);
        wr(2'h1, 4'hc, 16'h0456);
        res(4'h1, 1'b1, 4'h9, 16'h0123);
        res(4'h2, 1'b1, 4'h9, 16'h0123);
        res(4'h3, 1'b0, 4'h0, 16'h0000);
    endtask : t_prio

    task t_match;
        ev(mk(2'h0, 2'h1, 1'b0, 1'b0, 0, 0), 4'h1, 1'b0);
        ev(mk(2'h1, 2'h1, 1'b0, 1'b1, `H_DMAC(4'h1), 0), 4'h1, 1'b1);
        ev(mk(2'h1, 2'h1, 1'b0, 1'b0, `H_DMAC(4'h1), 0), 4'h2, 1'b1);
        ev(mk(2'h1, 2'h1, 1'b1, 1'b1, `H_SMAC(4'h2), 0), 4'h2, 1'b1);
        ev(mk(2'h1, 2'h1, 1'b1, 1'b1, `H_DMAC(4'h2), 0), 4'h2, 1'b0);
        ev(mk(2'h1, 2'h2, 1'b0, 1'b1, 0, `H_TYPE(4'h2)), 4'h2, 1'b1);
        ev(mk(2'h1, 2'h2, 1'b0, 1'b1, 0, `H_TYPE(4'h2)), 4'h1, 1'b0);
        ev(mk(2'h1, 2'h3, 1'b0, 1'b1, `H_DMAC(4'h1), `H_TYPE(4'h2)),
            4'h1, 1'b0);
        ev(mk(2'h2, 2'h1, 1'b0, 1'b1, `H_DIP(4'h0), 32'hf), 4'h5, 1'b1);
        ev(mk(2'h2, 2'h1, 1'b0, 1'b1, `H_DIP(4'h0), 32'h7), 4'h9, 1'b0);
        ev(mk(2'h2, 2'h1, 1'b1, 1'b1, `H_SIP(4'h3), 0), 4'h3, 1'b1);
        ev(mk(2'h2, 2'h2, 1'b0, 1'b1, `H_SIP(4'h4), `H_DIP(4'h4)),
            4'h4, 1'b1);
        ev(mk(2'h2, 2'h2, 1'b0, 1'b1, `H_SIP(4'h4), `H_DIP(4'h5)),
            4'h4, 1'b0);
        ev(mk(2'h2, 2'h0, 1'b0, 1'b0, 0, 0), 4'h1, 1'b0);
        ev(mk(2'h2, 2'h3, 1'b0, 1'b0, 0, 0), 4'h1, 1'b0);
        ev(mk(2'h3, 2'h0, 1'b0, 1'b1, `H_PROTO(4'h6), 0), 4'h6, 1'b1);
        ev(mk(2'h3, 2'h0, 1'b0, 1'b1, `H_PROTO(4'h6), 0), 4'h7, 1'b0);
        ev(mk(2'h3, 2'h1, 1'b0, 1'b1, {`H_DPORT(4'h5), `H_DPORT(4'h1)}, 0),
            4'h3, 1'b1);
        ev(mk(2'h3, 2'h1, 1'b0, 1'b1, {`H_DPORT(4'h5), `H_DPORT(4'h1)}, 0),
            4'h7, 1'b0);
        ev(mk(2'h3, 2'h2, 1'b1, 1'b1, {`H_SPORT(4'h4), `H_SPORT(4'h2)}, 0),
            4'h4, 1'b1);
        ev(mk(2'h3, 2'h2, 1'b1, 1'b1, {`H_SPORT(4'h4), `H_SPORT(4'h2)}, 0),
            4'h3, 1'b0);
        ev(mk(2'h3, 2'h3, 1'b0, 1'b1, `H_SEQ(4'h5), 0), 4'h5, 1'b1);
        ev(mk(2'h3, 2'h3, 1'b0, 1'b1, `H_SEQ(4'h5), 0), 4'h7, 1'b0);
    endtask : t_match

    task t_count;
        wr(2'h0, 4'h4, mk(2'h1, 2'h0, 1'b0, 1'b1, `H_DMAC(4'h1),
            `H_TYPE(4'h1)));
        wr(2'h2, 4'h0, {16'h0010, 4'h4});
        wr(2'h1, 4'h4, 16'h4003);
        res(4'h1, 1'b0, 4'h0, 16'h0000);
        chk("count_event", 0, count_event);
        res(4'h1, 1'b0, 4'h0, 16'h0000);
        chk("count_event", 0, count_event);
        res(4'h1, 1'b0, 4'h0, 16'h0000);
        chk("count_event", 16'h0010, count_event);
        wr(2'h1, 4'h4, 16'h0002);
        wt(3, 8);
        repeat (6) begin
            res(4'h1, 1'b0, 4'h0, 16'h0000);
            chk("count_event", 0, count_event);
        end
        wr(2'h1, 4'h4, 16'h8002);
        wt(8, 16);
    endtask : t_count

    initial begin
        #200000;
        n_fail++;
        close_out();
    end

    initial begin
        rst();
        t_prio();
        rst();
        t_match();
        t_count();
        close_out();
    end
endmodule : acl_rule_match_resolver_test

bind acl_rule_match_resolver acl_resolver_chk u_chk (.CLK(CLK),
    .RSTN(RSTN), .CFG_WE(CFG_WE), .PKT_VALID(PKT_VALID),
    .RESULT_VALID(RESULT_VALID), .ACTION_HIT(ACTION_HIT),
    .ACTION_INDEX(ACTION_INDEX), .ACTION_DATA(ACTION_DATA),
    .MATCH_RESULTS(MATCH_RESULTS), .COUNT_EVENT(COUNT_EVENT));
`default_nettype wire
